/* File: hw/talker_listener_pkg.sv */
/*
  Shared constants and types for the instrument-side talker/listener port:
  timing, address layout, interface command codes and the handshake states.
  Assumes a single 125 MHz clock and bus inputs already synchronous to it.
*/
package talker_listener_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLOCK_MHZ     = 125;
  // data settle time before data valid is asserted
  localparam int SETTLE_NS     = 2000;
  localparam int SETTLE_CYCLES = (SETTLE_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SETTLE_W      = $clog2(SETTLE_CYCLES + 1);

  // ************************************************************
  // addressing
  // ************************************************************
  localparam int         ADDR_W            = 5;
  localparam int         SWITCH_W          = 6;
  localparam logic [4:0] DEFAULT_ADDRESS   = 5'h03;
  localparam logic [4:0] FORBIDDEN_ADDRESS = 5'h1f;
  localparam logic [1:0] TALK_GROUP        = 2'h2;
  localparam logic [1:0] LISTEN_GROUP      = 2'h1;

  // ************************************************************
  // interface commands, seven bits, top data line ignored
  // ************************************************************
  localparam int         CMD_W   = 7;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;

  // ************************************************************
  // data path
  // ************************************************************
  localparam int         DATA_W     = 8;
  localparam int         TX_W       = DATA_W + 1;
  localparam int         FIFO_DEPTH = 8;
  localparam logic [7:0] LINE_FEED  = 8'h0a;
  localparam int         STATUS_W   = 6;
  localparam int         RSV_BIT    = 6;

  // ************************************************************
  // handshake states
  // ************************************************************
  typedef enum logic [1:0] {
    AH_IDLE,
    AH_READY,
    AH_DONE
  } acceptor_e;

  typedef enum logic [1:0] {
    SH_IDLE,
    SH_SETTLE,
    SH_VALID
  } source_e;

endpackage

/* File: hw/talker_listener_port.sv */
/*
  Instrument-side talker/listener port for the sixteen-line instrument bus:
  acceptor and source handshakes, address recognition, remote/local,
  serial poll with service request, trigger and clear, talk-only mode.
  Assumes bus lines are in logic sense (line low = 0), already synchronous
  to clock; open-drain lines are resolved outside from the enables.
*/
// Functional notes
// - talker pulls data-valid low only with valid data
// - listener holds not-ready and not-accepted low
// - attention low: data lines carry controller commands
// - attention high: data lines carry talker data
// - interface clear returns state machines to idle
// - service request line pulled low for attention
// - remote enable low plus listen gives remote
// - remote enable high reverts to local control
// - end line low marks last data byte
// - end asserted with terminating line feed
// - no identify; end under attention ignored
// - program strings accepted only remote and listening
// - bias switching and recalibration rejected remotely
// - default address 00011, talk C, listen #
// - address from switch positions five to one
// - open switch reads one, closed zero
// - talk group 10, listen group 01
// - talk-only sends without any addressing
// - mode input picks talk/listen or talk-only
// - trigger while addressed starts a measurement
`timescale 1ns/100ps
module talker_listener_port
  import talker_listener_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic                clock,
  input  wire logic                arst_n,
  // bus data lines
  input  wire logic [DATA_W-1:0]   dio_in,
  output logic      [DATA_W-1:0]   dio_out,
  output logic                     dio_oe,
  // handshake lines, open drain
  input  wire logic                dav_in,
  output logic                     dav_out,
  output logic                     dav_oe,
  input  wire logic                nrfd_in,
  output logic                     nrfd_out,
  output logic                     nrfd_oe,
  input  wire logic                ndac_in,
  output logic                     ndac_out,
  output logic                     ndac_oe,
  // management lines
  input  wire logic                atn_in,
  input  wire logic                ifc_in,
  input  wire logic                ren_in,
  output logic                     srq_out,
  output logic                     srq_oe,
  input  wire logic                eoi_in,
  output logic                     eoi_out,
  output logic                     eoi_oe,
  // configuration switches
  input  wire logic [SWITCH_W-1:0] address_select_switch,
  input  wire logic                talk_only_mode,
  // measurement output stream
  input  wire logic                tx_valid,
  output logic                     tx_ready,
  input  wire logic [DATA_W-1:0]   tx_data,
  input  wire logic                tx_last,
  // received program bytes
  output logic                     rx_valid,
  output logic      [DATA_W-1:0]   rx_data,
  output logic                     rx_end,
  // instrument events and status
  input  wire logic                service_request,
  input  wire logic [STATUS_W-1:0] poll_status,
  output logic                     trigger,
  output logic                     device_clear,
  output logic                     remote,
  output logic                     talk_active,
  output logic                     listen_active,
  // remotely requested front-panel functions
  input  wire logic                remote_func_valid,
  input  wire logic                remote_func_protected,
  output logic                     func_accept,
  output logic                     func_reject
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [DATA_W-1:0] dio_out;
    logic              dio_oe;
    logic              dav_oe;
    logic              nrfd_oe;
    logic              ndac_oe;
    logic              eoi_oe;
    logic              srq_oe;
    logic              low;
    logic              talk;
    logic              listen;
    logic              remote;
    logic              spoll;
    logic              rsv;
    logic              sent_poll;
    acceptor_e         ah;
    source_e           sh;
    logic [SETTLE_W-1:0] count;
    logic              rx_valid;
    logic [DATA_W-1:0] rx_data;
    logic              rx_end;
    logic              trigger;
    logic              dev_clear;
    logic              func_accept;
    logic              func_reject;
  } port_state_s;

  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYCLES - 1);

  port_state_s       s;
  port_state_s       next_s;
  logic              fifo_valid;
  logic [TX_W-1:0]   fifo_data;
  logic              fifo_pop;
  logic              fifo_ready;
  logic [ADDR_W-1:0] my_addr;
  logic [CMD_W-1:0]  cmd;
  logic              attention;
  logic              participate;
  logic              talker_on;
  logic              source_ok;
  logic              poll_byte;

  // ************************************************************
  // output buffer
  // ************************************************************
  // back-pressure reaches the producer through tx_ready
  tx_fifo #(
    .WIDTH (TX_W),
    .DEPTH (DEPTH)
  ) u_tx_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (tx_valid),
    .in_ready  (fifo_ready),
    .in_data   ({tx_last, tx_data}),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_s = s;
    fifo_pop = 1'b0;
    next_s.rx_valid    = 1'b0;
    next_s.trigger     = 1'b0;
    next_s.dev_clear   = 1'b0;
    next_s.func_accept = 1'b0;
    next_s.func_reject = 1'b0;

    // switch bits 4..0 are positions 5..1; position 6 is never read
    my_addr = address_select_switch[ADDR_W-1:0];
    // the all-ones setting would alias untalk/unlisten: fall back to default
    if (my_addr == FORBIDDEN_ADDRESS) begin
      my_addr = DEFAULT_ADDRESS;
    end
    cmd         = dio_in[CMD_W-1:0];
    attention   = !atn_in;
    // in talk-only there is no listener role at all
    participate = attention || (s.listen && !talk_only_mode);
    talker_on   = talk_only_mode || s.talk;
    source_ok   = talker_on && atn_in;
    poll_byte   = s.spoll && s.talk && !talk_only_mode;

    // remote / local
    if (ren_in) begin
      next_s.remote = 1'b0;
    end else if (s.listen) begin
      next_s.remote = 1'b1;
    end

    // acceptor handshake
    unique case (s.ah)
      AH_IDLE: begin
        if (participate && dav_in) begin
          next_s.ah = AH_READY;
        end
      end
      AH_READY: begin
        if (!participate) begin
          next_s.ah = AH_IDLE;
        end else if (!dav_in) begin
          next_s.ah = AH_DONE;
          if (attention) begin
            // eoi is not looked at here: no parallel poll response
            if (!talk_only_mode) begin
              if (cmd == {LISTEN_GROUP, my_addr}) begin
                next_s.listen = 1'b1;
              end else if (cmd == CMD_UNL) begin
                next_s.listen = 1'b0;
              end
              // any other talk address, untalk included, drops our talker
              if (cmd[CMD_W-1 -: 2] == TALK_GROUP) begin
                next_s.talk = cmd[ADDR_W-1:0] == my_addr;
              end
              if (cmd == CMD_GET && s.listen) begin
                next_s.trigger = 1'b1;
              end
              if (cmd == CMD_DCL || (cmd == CMD_SDC && s.listen)) begin
                next_s.dev_clear = 1'b1;
              end
              if (cmd == CMD_SPE) begin
                next_s.spoll = 1'b1;
              end else if (cmd == CMD_SPD) begin
                next_s.spoll = 1'b0;
              end
            end
          end else if (s.listen && s.remote) begin
            next_s.rx_valid = 1'b1;
            next_s.rx_data  = dio_in;
            next_s.rx_end   = !eoi_in;
          end
        end
      end
      AH_DONE: begin
        if (dav_in) begin
          next_s.ah = participate ? AH_READY : AH_IDLE;
        end
      end
    endcase

    // source handshake
    unique case (s.sh)
      SH_IDLE: begin
        if (source_ok && (poll_byte || fifo_valid)) begin
          next_s.sent_poll = poll_byte;
          next_s.dio_oe    = 1'b1;
          next_s.count     = '0;
          next_s.sh        = SH_SETTLE;
          if (poll_byte) begin
            next_s.dio_out          = '0;
            next_s.dio_out[RSV_BIT] = s.rsv;
            next_s.dio_out[STATUS_W-1:0] = poll_status;
            next_s.eoi_oe = 1'b0;
          end else begin
            next_s.dio_out = fifo_data[DATA_W-1:0];
            // end rides only on the line feed closing the message
            next_s.eoi_oe  = fifo_data[DATA_W]
                             && fifo_data[DATA_W-1:0] == LINE_FEED;
          end
        end
      end
      SH_SETTLE: begin
        if (!source_ok) begin
          next_s.sh = SH_IDLE;
        end else if (s.count != SETTLE_LAST) begin
          next_s.count = s.count + 1'b1;
        end else if (nrfd_in) begin
          next_s.dav_oe = 1'b1;
          next_s.sh     = SH_VALID;
        end
      end
      SH_VALID: begin
        if (!source_ok) begin
          next_s.sh = SH_IDLE;
        end else if (ndac_in) begin
          next_s.sh = SH_IDLE;
          if (s.sent_poll) begin
            next_s.rsv = s.rsv && !s.dio_out[RSV_BIT];
          end else begin
            fifo_pop = 1'b1;
          end
        end
      end
      default: begin
        next_s.sh = SH_IDLE;
      end
    endcase

    // a byte cut short by attention stays in the buffer and is resent
    if (next_s.sh == SH_IDLE) begin
      next_s.dav_oe = 1'b0;
      next_s.dio_oe = 1'b0;
      next_s.eoi_oe = 1'b0;
    end

    // a new request wins over a clear in the same cycle
    if (service_request) begin
      next_s.rsv = 1'b1;
    end

    // interface clear
    if (!ifc_in) begin
      next_s.talk   = 1'b0;
      next_s.listen = 1'b0;
      next_s.spoll  = 1'b0;
      next_s.ah     = AH_IDLE;
      next_s.sh     = SH_IDLE;
      next_s.dav_oe = 1'b0;
      next_s.dio_oe = 1'b0;
      next_s.eoi_oe = 1'b0;
      fifo_pop      = 1'b0;
    end

    next_s.ndac_oe = next_s.ah == AH_READY;
    next_s.nrfd_oe = next_s.ah == AH_DONE;
    next_s.srq_oe  = next_s.rsv;

    // protected functions are refused from the remote side
    if (remote_func_valid) begin
      next_s.func_reject = remote_func_protected;
      next_s.func_accept = !remote_func_protected;
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign dio_out       = s.dio_out;
  assign dio_oe        = s.dio_oe;
  assign dav_out       = s.low;
  assign dav_oe        = s.dav_oe;
  assign nrfd_out      = s.low;
  assign nrfd_oe       = s.nrfd_oe;
  assign ndac_out      = s.low;
  assign ndac_oe       = s.ndac_oe;
  assign srq_out       = s.low;
  assign srq_oe        = s.srq_oe;
  assign eoi_out       = s.low;
  assign eoi_oe        = s.eoi_oe;
  assign tx_ready      = fifo_ready;
  assign rx_valid      = s.rx_valid;
  assign rx_data       = s.rx_data;
  assign rx_end        = s.rx_end;
  assign trigger       = s.trigger;
  assign device_clear  = s.dev_clear;
  assign remote        = s.remote;
  assign talk_active   = s.talk;
  assign listen_active = s.listen;
  assign func_accept   = s.func_accept;
  assign func_reject   = s.func_reject;

endmodule

/* File: hw/tx_fifo.sv */
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; ready and valid flags come straight from flip-flops.
*/
`timescale 1ns/100ps
module tx_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
    logic                        in_ready;
    logic                        out_valid;
  } fifo_state_s;

  fifo_state_s s;
  fifo_state_s next_s;
  logic        push;
  logic        pop;

  always_comb begin
    next_s = s;
    push   = in_valid && s.in_ready;
    pop    = s.out_valid && out_ready;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = (s.wr == LAST) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = (s.rd == LAST) ? '0 : s.rd + 1'b1;
    end
    next_s.count     = s.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // flags follow the new count so the source sees full as soon as the count reaches it, with no cycle of lag
    next_s.in_ready  = next_s.count != FULL;
    next_s.out_valid = next_s.count != '0;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign in_ready  = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_data  = s.mem[s.rd];

endmodule

/* File: test/bus_partner_model.sv */
/*
  bus controller and printer-like listener on the far side of the port.
  assumes logic-sense pins; released lines read true (pull-ups).
*/
`timescale 1ns/100ps
module bus_partner_model
  import talker_listener_pkg::*;
(
  input  wire logic              clock,
  input  wire logic [DATA_W-1:0] dio_out,
  input  wire logic              dio_oe,
  input  wire logic              dav_oe,
  input  wire logic              nrfd_oe,
  input  wire logic              ndac_oe,
  input  wire logic              eoi_oe,
  output logic      [DATA_W-1:0] dio_in,
  output logic                   dav_in,
  output logic                   nrfd_in,
  output logic                   ndac_in,
  output logic                   eoi_in,
  output logic                   got_valid,
  output logic      [DATA_W:0]   got_byte
);
  // ****************************************
  // wired lines and handshakes
  // ****************************************
  logic [7:0] c_dio = 8'h00;
  logic       c_doe = 1'b0;
  logic       c_dav = 1'b0;
  logic       c_nrfd = 1'b0;
  logic       c_ndac = 1'b0;
  logic       c_eoi = 1'b0;
  logic       listen_on = 1'b0;
  logic       stuck = 1'b0;
  int         slow = 0;
  int         w;

  initial {got_valid, got_byte} = 10'h000;
  assign dio_in  = dio_oe ? dio_out : (c_doe ? c_dio : 8'h00);
  assign dav_in  = !(dav_oe || c_dav);
  assign nrfd_in = !(nrfd_oe || c_nrfd);
  assign ndac_in = !(ndac_oe || c_ndac);
  assign eoi_in  = !(eoi_oe || c_eoi);

  task automatic send(input logic [7:0] d, input logic e);
    int n;
    @(negedge clock);
    c_dio = d;
    c_doe = 1'b1;
    c_eoi = e;
    repeat (3) @(negedge clock);
    n = 0;
    while (!nrfd_in && n < 500) begin
      @(negedge clock);
      n++;
    end
    c_dav = 1'b1;
    @(negedge clock);
    while (!ndac_in && n < 500) begin
      @(negedge clock);
      n++;
    end
    if (n >= 500) stuck = 1'b1;
    c_dav = 1'b0;
    @(negedge clock);
    c_doe = 1'b0;
    c_eoi = 1'b0;
  endtask

  // listener: slow > 0 keeps not-ready low after each byte
  always begin
    @(negedge clock);
    c_ndac = listen_on;
    c_nrfd = 1'b0;
    if (listen_on && !dav_in) begin
      c_nrfd = 1'b1;
      got_byte = {!eoi_in, dio_in};
      got_valid = 1'b1;
      @(negedge clock);
      got_valid = 1'b0;
      c_ndac = 1'b0;
      w = 0;
      while (!dav_in && w < 500) begin
        @(negedge clock);
        w++;
      end
      if (w >= 500) stuck = 1'b1;
      repeat (slow) @(negedge clock);
    end
  end
endmodule

/* File: test/talker_listener_port_test.sv */
/*
  self-checking bench for the talker/listener port.
  assumes the partner model resolves the wired lines.
*/
`timescale 1ns/100ps
module talker_listener_port_test;
  import talker_listener_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  logic       clock = 1'b0;
  logic       arst_n, atn_in, ifc_in, ren_in, talk_only_mode, tx_valid, tx_ready, tx_last;
  logic       service_request, remote_func_valid, remote_func_protected, func_accept;
  logic       func_reject, dio_oe, dav_in, dav_oe, nrfd_in, nrfd_oe, ndac_in, ndac_oe;
  logic       srq_oe, eoi_in, eoi_oe, rx_valid, rx_end, trigger, device_clear;
  logic       remote, talk_active, listen_active, got_valid;
  logic [7:0] dio_in, dio_out, tx_data, rx_data, d;
  logic [5:0] address_select_switch, poll_status;
  logic [8:0] got_byte, rxq[$], gotq[$];
  logic [4:0] a;
  int         failures = 0, comparisons = 0, trig_n = 0, clr_n = 0, seed;

  always #4 clock = !clock;

  talker_listener_port u_talker_listener_port (
    .clock, .arst_n, .dio_in, .dio_out, .dio_oe, .dav_in, .dav_out(), .dav_oe,
    .nrfd_in, .nrfd_out(), .nrfd_oe, .ndac_in, .ndac_out(), .ndac_oe, .atn_in,
    .ifc_in, .ren_in, .srq_out(), .srq_oe, .eoi_in, .eoi_out(), .eoi_oe,
    .address_select_switch, .talk_only_mode, .tx_valid, .tx_ready, .tx_data,
    .tx_last, .rx_valid, .rx_data, .rx_end, .service_request, .poll_status,
    .trigger, .device_clear, .remote, .talk_active, .listen_active,
    .remote_func_valid, .remote_func_protected, .func_accept, .func_reject);

  bus_partner_model u_bus_partner_model (
    .clock, .dio_out, .dio_oe, .dav_oe, .nrfd_oe, .ndac_oe, .eoi_oe, .dio_in,
    .dav_in, .nrfd_in, .ndac_in, .eoi_in, .got_valid, .got_byte);

  // ****************************************
  // tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic flag(input string m);
    failures++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic expect1(input logic got, input logic want, input string m);
    comparisons++;
    if (got !== want) flag(m);
  endtask
  task automatic bus(input logic at, input logic [7:0] v, input logic e);
    @(negedge clock);
    atn_in = at;
    u_bus_partner_model.send(v, e);
  endtask
  // the end line is expected only with the last line feed
  task automatic push(input logic [7:0] v, input logic l);
    int n;
    @(negedge clock);
    tx_valid = 1'b1;
    tx_data = v;
    tx_last = l;
    gotq.push_back({l, v});
    for (n = 0; tx_ready !== 1'b1 && n < 3000; n++) @(negedge clock);
    if (n >= 3000) flag("push stuck");
    if (n >= 3000) tally_and_finish();
    @(negedge clock);
    tx_valid = 1'b0;
  endtask

  task automatic drain();
    int n;
    for (n = 0; gotq.size() != 0 && n < 6000; n++) @(negedge clock);
    if (n >= 6000) flag("drain stuck");
    if (n >= 6000) tally_and_finish();
  endtask

  always @(posedge clock) begin
    if (rx_valid === 1'b1) begin
      comparisons++;
      if (rxq.size() == 0 || rxq.pop_front() !== {rx_end, rx_data}) flag("rx byte");
    end
    if (got_valid === 1'b1) begin
      comparisons++;
      if (gotq.size() == 0 || gotq.pop_front() !== got_byte) flag("tx byte");
    end
    if (trigger === 1'b1) trig_n++;
    if (device_clear === 1'b1) clr_n++;
  end

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {arst_n, tx_valid, tx_last, service_request, talk_only_mode} = 5'h00;
    {atn_in, ifc_in, ren_in, remote_func_valid, remote_func_protected} = 5'h1c;
    {tx_data, poll_status, address_select_switch} = 20'h00000;
    seed = $urandom(32'h5b93b42a);
    repeat (2) @(negedge clock);
    expect1(tx_ready | dio_oe | dav_oe | srq_oe | listen_active, 1'b0, "reset");
    arst_n = 1'b1;
    repeat (2) @(negedge clock);
    for (int i = 0; i < 4; i++) begin
      a = (i == 3) ? 5'h03 : 5'($urandom_range(30));
      address_select_switch = {1'($urandom), a};
      bus(1'b0, {3'h1, a ^ 5'h01}, 1'b0);
      expect1(listen_active, 1'b0, "other address");
      bus(1'b0, {3'h1, a}, 1'b1);
      expect1(listen_active, 1'b1, "own address");
      bus(1'b0, {1'b0, CMD_UNL}, 1'b0);
      expect1(listen_active, 1'b0, "unlisten");
    end
    ren_in = 1'b0;
    bus(1'b0, {3'h1, a}, 1'b0);
    expect1(remote, 1'b1, "remote");
    for (int i = 0; i < 3; i++) begin
      d = 8'($urandom);
      rxq.push_back({i == 2, d});
      bus(1'b1, d, i == 2);
    end
    bus(1'b0, {1'b0, CMD_GET}, 1'b1);
    bus(1'b0, {1'b0, CMD_DCL}, 1'b0);
    bus(1'b0, {1'b0, CMD_SDC}, 1'b0);
    expect1(trig_n == 1 && clr_n == 2, 1'b1, "trigger or clear");
    for (int p = 1; p >= 0; p--) begin
      remote_func_protected = p[0];
      remote_func_valid = 1'b1;
      @(negedge clock);
      remote_func_valid = 1'b0;
      expect1(func_reject, p[0], "reject");
      expect1(func_accept, !p[0], "accept");
    end
    bus(1'b0, {1'b0, CMD_UNL}, 1'b0);
    bus(1'b1, 8'h55, 1'b0);
    ren_in = 1'b1;
    @(negedge clock);
    expect1(remote, 1'b0, "local");
    bus(1'b0, {3'h1, a}, 1'b0);
    bus(1'b1, 8'h33, 1'b1);
    expect1(remote, 1'b0, "still local");
    bus(1'b0, {1'b0, CMD_UNL}, 1'b0);
    bus(1'b0, {3'h2, a}, 1'b0);
    expect1(talk_active, 1'b1, "talk address");
    atn_in = 1'b1;
    u_bus_partner_model.slow = 30;
    u_bus_partner_model.listen_on = 1'b1;
    for (int i = 0; i < FIFO_DEPTH; i++) push((i % 4 == 3) ? LINE_FEED : 8'($urandom), i == 7);
    repeat (2) @(negedge clock);
    expect1(tx_ready, 1'b0, "fifo full");
    push(8'($urandom), 1'b0);
    drain();
    u_bus_partner_model.listen_on = 1'b0;
    poll_status = 6'($urandom);
    service_request = 1'b1;
    @(negedge clock);
    service_request = 1'b0;
    repeat (2) @(negedge clock);
    expect1(srq_oe, 1'b1, "service request");
    bus(1'b0, {1'b0, CMD_SPE}, 1'b0);
    gotq.push_back({3'h1, poll_status});
    atn_in = 1'b1;
    u_bus_partner_model.slow = 0;
    u_bus_partner_model.listen_on = 1'b1;
    drain();
    u_bus_partner_model.listen_on = 1'b0;
    repeat (2) @(negedge clock);
    expect1(srq_oe, 1'b0, "request served");
    bus(1'b0, {1'b0, CMD_SPD}, 1'b0);
    ifc_in = 1'b0;
    @(negedge clock);
    ifc_in = 1'b1;
    expect1(talk_active | listen_active, 1'b0, "interface clear");
    talk_only_mode = 1'b1;
    bus(1'b0, {3'h1, a}, 1'b0);
    expect1(listen_active, 1'b0, "talk-only listen");
    atn_in = 1'b1;
    u_bus_partner_model.listen_on = 1'b1;
    for (int i = 0; i < 3; i++) push((i == 2) ? LINE_FEED : 8'($urandom), i == 2);
    drain();
    expect1(u_bus_partner_model.stuck, 1'b0, "partner wait");
    expect1(rxq.size() == 0, 1'b1, "rx left over");
    tally_and_finish();
  end
endmodule

/* File: test/talker_listener_props.sv */
/*
  concurrent checks on the talker/listener port pins.
  assumes the pins as the port sees them, one clock; bound below.
*/
`timescale 1ns/100ps
module talker_listener_props
  import talker_listener_pkg::*;
(
  input wire logic              clock,
  input wire logic              arst_n,
  input wire logic [DATA_W-1:0] dio_out,
  input wire logic              dio_oe,
  input wire logic              dav_in,
  input wire logic              dav_oe,
  input wire logic              nrfd_in,
  input wire logic              nrfd_oe,
  input wire logic              ndac_in,
  input wire logic              ndac_oe,
  input wire logic              atn_in,
  input wire logic              ifc_in,
  input wire logic              ren_in,
  input wire logic              eoi_oe,
  input wire logic              remote,
  input wire logic              talk_active,
  input wire logic              listen_active,
  input wire logic              remote_func_valid,
  input wire logic              remote_func_protected,
  input wire logic              func_accept,
  input wire logic              func_reject
);
  // ****************************************
  // pin properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_valid_with_data: assert property (dav_oe |-> dio_oe)
    else $error("valid without data");
  a_ready_before_valid: assert property ($rose(dav_oe) |-> $past(nrfd_in))
    else $error("valid before ready");
  // an abort by attention or clear may release early
  a_accept_before_release: assert property ($fell(dav_oe) |->
    $past(ndac_in) || !$past(atn_in) || !$past(ifc_in))
    else $error("release before accept");
  a_accept_answer: assert property (ndac_oe && !nrfd_oe && !dav_in && ifc_in
    |=> nrfd_oe && !ndac_oe)
    else $error("byte not acknowledged");
  a_end_on_lf: assert property (eoi_oe |-> dio_oe && dio_out == LINE_FEED)
    else $error("end without line feed");
  a_attn_quiet: assert property (!$past(atn_in) |-> !dio_oe && !eoi_oe)
    else $error("talking under attention");
  a_ifc_clears: assert property (!ifc_in |=> !talk_active && !listen_active)
    else $error("clear ignored");
  a_ren_local: assert property (ren_in |=> !remote)
    else $error("remote without enable");
  a_remote_listen: assert property (!ren_in && listen_active |=> remote)
    else $error("no remote");
  a_func_reject: assert property (remote_func_valid && remote_func_protected
    |=> func_reject && !func_accept)
    else $error("protected function taken");
endmodule

bind talker_listener_port talker_listener_props u_talker_listener_props (
  .clock, .arst_n, .dio_out, .dio_oe, .dav_in, .dav_oe, .nrfd_in, .nrfd_oe,
  .ndac_in, .ndac_oe, .atn_in, .ifc_in, .ren_in, .eoi_oe, .remote,
  .talk_active, .listen_active, .remote_func_valid, .remote_func_protected,
  .func_accept, .func_reject);
